// >>> hdl/pwm_timer_pkg.sv
// constants, register map and field layout of the dual-slope pwm timer
package pwm_timer_pkg;

	// ------------------------------------------------------------
	// bus widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
	localparam logic [ADDR_W-1:0] CMP_A_OFS   = 8'h04;
	localparam logic [ADDR_W-1:0] CMP_B_OFS   = 8'h08;
	localparam logic [ADDR_W-1:0] CAPTURE_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] COUNT_OFS   = 8'h10;
	localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h14;
	localparam logic [ADDR_W-1:0] MASK_OFS    = 8'h18;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int MODE_LSB = 0;
	localparam int MODE_W   = 4;
	localparam int COMA_LSB = 4;
	localparam int COMB_LSB = 6;
	localparam int COM_W    = 2;
	localparam int CS_LSB   = 8;
	localparam int CS_W     = 3;
	localparam int CTRL_W   = 11;

	// waveform_mode_select codes for the dual-slope modes
	localparam logic [MODE_W-1:0] MODE_PFC_CAPTURE = 4'h8;
	localparam logic [MODE_W-1:0] MODE_PFC_CMPA    = 4'h9;
	localparam logic [MODE_W-1:0] MODE_PC_CAPTURE  = 4'ha;
	localparam logic [MODE_W-1:0] MODE_PC_CMPA     = 4'hb;

	// compare output modes
	localparam logic [COM_W-1:0] COM_OFF    = 2'h0;
	localparam logic [COM_W-1:0] COM_TOGGLE = 2'h1;
	localparam logic [COM_W-1:0] COM_NONINV = 2'h2;
	localparam logic [COM_W-1:0] COM_INV    = 2'h3;

	// count clock select
	localparam logic [CS_W-1:0] CS_STOP     = 3'h0;
	localparam logic [CS_W-1:0] CS_DIV1     = 3'h1;
	localparam logic [CS_W-1:0] CS_DIV8     = 3'h2;
	localparam logic [CS_W-1:0] CS_DIV64    = 3'h3;
	localparam logic [CS_W-1:0] CS_DIV256   = 3'h4;
	localparam logic [CS_W-1:0] CS_DIV1024  = 3'h5;
	localparam logic [CS_W-1:0] CS_EXT_FALL = 3'h6;
	localparam logic [CS_W-1:0] CS_EXT_RISE = 3'h7;

	// prescaler
	localparam int PRESC_W = 10;
	localparam logic [PRESC_W-1:0] PRESC_STEP     = 10'h001;
	localparam logic [PRESC_W-1:0] PRESC_MASK8    = 10'h007;
	localparam logic [PRESC_W-1:0] PRESC_MASK64   = 10'h03f;
	localparam logic [PRESC_W-1:0] PRESC_MASK256  = 10'h0ff;
	localparam logic [PRESC_W-1:0] PRESC_MASK1024 = 10'h3ff;

	// ------------------------------------------------------------
	// counter values and status bits
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] BOTTOM     = 16'h0000;
	localparam logic [DATA_W-1:0] MAX        = 16'hffff;
	localparam logic [DATA_W-1:0] COUNT_STEP = 16'h0001;
	localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;

	localparam int STATUS_W = 3;
	localparam int ST_OVF   = 0;
	localparam int ST_CMPA  = 1;
	localparam int ST_CMPB  = 2;

	// pin edge to counter update, in tenths of a system clock cycle
	localparam int EXT_LAT_MIN_X10 = 25;
	localparam int EXT_LAT_MAX_X10 = 35;
	// the same latency in whole cycles from the sampling edge
	localparam int EXT_PULSE_LAT = (EXT_LAT_MIN_X10 - 5) / 10;

endpackage

// >>> hdl/ext_edge_if.sv
// edge pulses passed from the count pin synchroniser to the timer
`timescale 1ns/1ps
interface ext_edge_if;
	logic rise_pulse;
	logic fall_pulse;

	modport source
	(
		output rise_pulse,
		output fall_pulse
	);
	modport sink
	(
		input  rise_pulse,
		input  fall_pulse
	);
endinterface

// >>> hdl/ext_count_sync.sv
// two-flop synchroniser and edge detector for the external count pin
`timescale 1ns/1ps
module ext_count_sync
	import pwm_timer_pkg::*;
(
	input  wire logic      core_clk_in,
	input  wire logic      rstn_in,
	input  wire logic      ext_count_pin_in,
	ext_edge_if.source     edge_if
);

	typedef struct packed
	{
		logic meta;
		logic sync;
		logic last;
	} sync_state_t;

	sync_state_t r_reg;
	sync_state_t r_next;

	// ------------------------------------------------------------
	// next state: meta feeds only sync
	// ------------------------------------------------------------
	always_comb
	begin
		r_next      = r_reg;
		r_next.meta = ext_count_pin_in;
		r_next.sync = r_reg.meta;
		r_next.last = r_reg.sync;
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	// edge pulses compare two settled stages only
	assign edge_if.rise_pulse = r_reg.sync & ~r_reg.last;
	assign edge_if.fall_pulse = ~r_reg.sync & r_reg.last;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	pin_rise_lat_a: assert property ($rose(ext_count_pin_in) |-> ##2 edge_if.rise_pulse)
		else $error("rise pulse not two cycles after pin rise");
	pin_fall_lat_a: assert property ($fell(ext_count_pin_in) |-> ##2 edge_if.fall_pulse)
		else $error("fall pulse not two cycles after pin fall");

endmodule

// >>> hdl/pwm_timer16.sv
// 16-bit timer with dual-slope pwm modes, external count pin and register port
//
// Function
// - count pin is synchronised and edge detected, counter moves 2.5-3.5 cycles later
// - selected pin edges drive the counter directly, bypassing the prescaler
// - compare at bottom gives constant low, at top constant high, inverted swaps
// - mode 11 with toggle output makes output a a 50% square wave
// - modes 8 and 9 select phase and frequency correct dual-slope pwm
// - counter runs up from zero to top then back down to zero
// - non-inverting output clears on up match, sets on down match
// - active compare values load from software buffers, not written directly
// - top comes from capture in mode 8, compare a in mode 9
// - counter stays at top for exactly one timer tick
// - each compare match sets that channel's status flag
`timescale 1ns/1ps
module pwm_timer16
	import pwm_timer_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              core_clk_in,
	input  wire logic              rstn_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              wr_en_in,
	input  wire logic              rd_en_in,
	input  wire logic              ext_count_pin_in,
	output logic      [DATA_W-1:0] rd_data_out,
	output logic                   compare_output_a_out,
	output logic                   compare_output_b_out,
	output logic                   irq_out
);

	typedef struct packed
	{
		logic [MODE_W-1:0]   mode;
		logic [COM_W-1:0]    com_a;
		logic [COM_W-1:0]    com_b;
		logic [CS_W-1:0]     clk_sel;
		logic [PRESC_W-1:0]  presc;
		logic [DATA_W-1:0]   cmp_a_buf;
		logic [DATA_W-1:0]   cmp_b_buf;
		logic [DATA_W-1:0]   cmp_a;
		logic [DATA_W-1:0]   cmp_b;
		logic [DATA_W-1:0]   capture;
		logic [DATA_W-1:0]   count;
		logic                dir_down;
		logic                out_a;
		logic                out_b;
		logic [STATUS_W-1:0] status;
		logic [STATUS_W-1:0] mask;
		logic [DATA_W-1:0]   rd_data;
	} timer_state_t;

	timer_state_t        r_reg;
	timer_state_t        r_next;
	logic                tick;
	logic                dual;
	logic                pfc;
	logic [DATA_W-1:0]   top;
	logic [DATA_W-1:0]   cnt_step;
	logic                match_a;
	logic                match_b;
	logic                reload;
	logic [STATUS_W-1:0] st_set;
	logic [STATUS_W-1:0] st_clr;

	ext_edge_if edge_bus ();

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic presc_hit(input logic [PRESC_W-1:0] p,
	                                   input logic [PRESC_W-1:0] m);
		presc_hit = ((p & m) == m);
	endfunction

	function automatic logic is_dual(input logic [MODE_W-1:0] m);
		is_dual = (m == MODE_PFC_CAPTURE) || (m == MODE_PFC_CMPA) ||
		          (m == MODE_PC_CAPTURE) || (m == MODE_PC_CMPA);
	endfunction

	// pwm channel output: extremes are forced, mid values follow the slope
	function automatic logic chan_next(input logic              cur,
	                                   input logic [DATA_W-1:0] cmp,
	                                   input logic [DATA_W-1:0] t,
	                                   input logic [COM_W-1:0]  com,
	                                   input logic              hit,
	                                   input logic              down);
		logic inv;
		inv = (com == COM_INV);
		if (cmp == BOTTOM)
			chan_next = inv;
		else if (cmp >= t)
			chan_next = ~inv;
		else if (hit)
			chan_next = down ? ~inv : inv;
		else
			chan_next = cur;
	endfunction

	// ------------------------------------------------------------
	// count pin synchroniser
	// ------------------------------------------------------------
	ext_count_sync u_sync
	(
		.core_clk_in      (core_clk_in),
		.rstn_in          (rstn_in),
		.ext_count_pin_in (ext_count_pin_in),
		.edge_if          (edge_bus)
	);

	// ------------------------------------------------------------
	// timer clock selection; pin edges skip the prescaler
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (r_reg.clk_sel)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = presc_hit(r_reg.presc, PRESC_MASK8);
			CS_DIV64:    tick = presc_hit(r_reg.presc, PRESC_MASK64);
			CS_DIV256:   tick = presc_hit(r_reg.presc, PRESC_MASK256);
			CS_DIV1024:  tick = presc_hit(r_reg.presc, PRESC_MASK1024);
			CS_EXT_FALL: tick = edge_bus.fall_pulse;
			CS_EXT_RISE: tick = edge_bus.rise_pulse;
		endcase
	end

	// ------------------------------------------------------------
	// mode decode, step and match
	// ------------------------------------------------------------
	always_comb
	begin
		dual = is_dual(r_reg.mode);
		pfc  = (r_reg.mode == MODE_PFC_CAPTURE) || (r_reg.mode == MODE_PFC_CMPA);
		// capture sets top for modes 8 and 10, compare a otherwise
		top  = ((r_reg.mode == MODE_PFC_CAPTURE) || (r_reg.mode == MODE_PC_CAPTURE)) ?
		       r_reg.capture : r_reg.cmp_a;
		// a top written below the count turns the counter round at once
		if (!dual)
			cnt_step = r_reg.count + COUNT_STEP;
		else if (!r_reg.dir_down && (r_reg.count < top))
			cnt_step = r_reg.count + COUNT_STEP;
		else if (r_reg.count != BOTTOM)
			cnt_step = r_reg.count - COUNT_STEP;
		else
			cnt_step = r_reg.count + COUNT_STEP;
		match_a = tick && (r_reg.count == r_reg.cmp_a);
		match_b = tick && (r_reg.count == r_reg.cmp_b);
		// frequency correct loads at bottom, phase correct at top
		reload  = tick && dual &&
		          (pfc ? ((cnt_step == BOTTOM) && (r_reg.count != BOTTOM))
		               : (r_reg.count == top));
	end

	// ------------------------------------------------------------
	// status events; a set in the clearing cycle survives
	// ------------------------------------------------------------
	always_comb
	begin
		st_set          = '0;
		st_set[ST_CMPA] = match_a;
		st_set[ST_CMPB] = match_b;
		st_set[ST_OVF]  = tick && (dual ? ((cnt_step == BOTTOM) && (r_reg.count != BOTTOM))
		                                : (r_reg.count == MAX));
		st_clr          = (wr_en_in && (addr_in == STATUS_OFS)) ? wr_data_in[STATUS_W-1:0] : '0;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		r_next         = r_reg;
		r_next.presc   = r_reg.presc + PRESC_STEP;
		r_next.status  = (r_reg.status & ~st_clr) | st_set;
		r_next.rd_data = RESET_WORD;

		// counter and direction
		if (tick)
		begin
			r_next.count = cnt_step;
			if (!dual || (cnt_step == BOTTOM))
				r_next.dir_down = 1'b0;
			else if (cnt_step >= top)
				r_next.dir_down = 1'b1;
		end

		// active compare values come only from the buffers
		if (!dual || reload)
		begin
			r_next.cmp_a = r_reg.cmp_a_buf;
			r_next.cmp_b = r_reg.cmp_b_buf;
		end

		// output a: toggle only where compare a is top
		if (dual && (r_reg.com_a == COM_TOGGLE) &&
		    ((r_reg.mode == MODE_PFC_CMPA) || (r_reg.mode == MODE_PC_CMPA)))
			r_next.out_a = match_a ? ~r_reg.out_a : r_reg.out_a;
		else if (dual && r_reg.com_a[1])
			r_next.out_a = chan_next(r_reg.out_a, r_reg.cmp_a, top, r_reg.com_a,
			                         match_a, r_reg.dir_down);
		else
			r_next.out_a = 1'b0;

		if (dual && r_reg.com_b[1])
			r_next.out_b = chan_next(r_reg.out_b, r_reg.cmp_b, top, r_reg.com_b,
			                         match_b, r_reg.dir_down);
		else
			r_next.out_b = 1'b0;

		// software writes; a count write beats the counting step
		if (wr_en_in)
		begin
			unique case (addr_in)
				CTRL_OFS:
				begin
					r_next.mode    = wr_data_in[MODE_LSB +: MODE_W];
					r_next.com_a   = wr_data_in[COMA_LSB +: COM_W];
					r_next.com_b   = wr_data_in[COMB_LSB +: COM_W];
					r_next.clk_sel = wr_data_in[CS_LSB +: CS_W];
				end
				CMP_A_OFS:   r_next.cmp_a_buf = wr_data_in;
				CMP_B_OFS:   r_next.cmp_b_buf = wr_data_in;
				CAPTURE_OFS: r_next.capture   = wr_data_in;
				COUNT_OFS:   r_next.count     = wr_data_in;
				MASK_OFS:    r_next.mask      = wr_data_in[STATUS_W-1:0];
				default:     ;
			endcase
		end

		// read data stands in the cycle after the strobe; unmapped reads zero
		if (rd_en_in)
		begin
			unique case (addr_in)
				CTRL_OFS:
				begin
					r_next.rd_data[MODE_LSB +: MODE_W] = r_reg.mode;
					r_next.rd_data[COMA_LSB +: COM_W]  = r_reg.com_a;
					r_next.rd_data[COMB_LSB +: COM_W]  = r_reg.com_b;
					r_next.rd_data[CS_LSB +: CS_W]     = r_reg.clk_sel;
				end
				CMP_A_OFS:   r_next.rd_data = r_reg.cmp_a_buf;
				CMP_B_OFS:   r_next.rd_data = r_reg.cmp_b_buf;
				CAPTURE_OFS: r_next.rd_data = r_reg.capture;
				COUNT_OFS:   r_next.rd_data = r_reg.count;
				STATUS_OFS:  r_next.rd_data[STATUS_W-1:0] = r_reg.status;
				MASK_OFS:    r_next.rd_data[STATUS_W-1:0] = r_reg.mask;
				default:     r_next.rd_data = RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign rd_data_out          = r_reg.rd_data;
	assign compare_output_a_out = r_reg.out_a;
	assign compare_output_b_out = r_reg.out_b;
	assign irq_out              = |(r_reg.status & r_reg.mask);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	ext_count_moves_a: assert property ((r_reg.clk_sel == CS_EXT_RISE) && !wr_en_in
		&& $rose(ext_count_pin_in) |-> ##2 tick)
		else $error("pin edge did not tick the counter in time");
	ext_no_presc_a: assert property ((r_reg.clk_sel == CS_EXT_RISE) && !edge_bus.rise_pulse
		&& !wr_en_in |=> $stable(r_reg.count))
		else $error("counter moved without a pin edge");
	low_extreme_a: assert property (dual && (r_reg.com_a == COM_NONINV)
		&& (r_reg.cmp_a == BOTTOM) |=> !compare_output_a_out)
		else $error("compare at bottom did not hold output low");
	high_extreme_a: assert property (dual && (r_reg.com_b == COM_INV) && (r_reg.cmp_b != BOTTOM)
		&& (r_reg.cmp_b >= top) |=> !compare_output_b_out)
		else $error("inverted compare at top did not hold output low");
	toggle_match_a: assert property ((r_reg.mode == MODE_PC_CMPA) && (r_reg.com_a == COM_TOGGLE)
		&& match_a |=> (compare_output_a_out != $past(compare_output_a_out)))
		else $error("output a did not toggle on match");
	top_turn_a: assert property (dual && tick && !wr_en_in && (r_reg.count == top)
		&& (top != BOTTOM) |=> (r_reg.count == $past(top) - COUNT_STEP) && r_reg.dir_down)
		else $error("counter did not turn at top");
	top_hold_a: assert property (dual && !tick && !wr_en_in && (r_reg.count == top)
		|=> $stable(r_reg.count))
		else $error("counter left top without a tick");
	bottom_turn_a: assert property (dual && tick && !wr_en_in && r_reg.dir_down
		&& (r_reg.count == COUNT_STEP) |=> (r_reg.count == BOTTOM) && !r_reg.dir_down
		##0 r_reg.status[ST_OVF])
		else $error("bottom not reached or overflow not flagged");
	up_clear_a: assert property (dual && (r_reg.com_b == COM_NONINV) && match_b && !r_reg.dir_down
		&& (r_reg.cmp_b != BOTTOM) && (r_reg.cmp_b < top) |=> !compare_output_b_out)
		else $error("up count match did not clear output");
	match_flag_a: assert property (match_a |=> r_reg.status[ST_CMPA])
		else $error("compare match a not flagged");
	pfc_reload_a: assert property (pfc && tick && !wr_en_in && r_reg.dir_down
		&& (r_reg.count == COUNT_STEP) |=> (r_reg.cmp_a == $past(r_reg.cmp_a_buf)))
		else $error("compare a not reloaded at bottom");
	buffer_only_a: assert property (dual && !reload |=> $stable(r_reg.cmp_a))
		else $error("active compare changed outside reload");

	pfc_overflow_c: cover property ((r_reg.mode == MODE_PFC_CMPA) && st_set[ST_OVF]);
	ext_tick_c: cover property ((r_reg.clk_sel == CS_EXT_RISE) && tick && dual);
	toggle_c: cover property ((r_reg.mode == MODE_PC_CMPA) && (r_reg.com_a == COM_TOGGLE) && match_a);
	irq_c: cover property (irq_out && (r_reg.mode == MODE_PFC_CAPTURE));

endmodule

// >>> test/ext_clock_source.sv
// model of the outside count clock source that drives the timer's count pin
`timescale 1ns/1ps
module ext_clock_source
(
	input  wire logic       core_clk_in,
	input  wire logic       en_in,
	input  wire logic [7:0] half_in,
	output logic            pin_out,
	output int              rises_out,
	output int              falls_out
);
	logic [7:0] cnt_reg;

	initial
	begin
		pin_out = 1'b0;
		cnt_reg = 8'h00;
		rises_out = 0;
		falls_out = 0;
	end

	// ------------------------------------------------------------
	// square wave, level held while stopped
	// ------------------------------------------------------------
	// holding the level when stopped lets software switch the clock select safely
	always @(posedge core_clk_in)
	begin
		if (!en_in)
			cnt_reg <= 8'h00;
		else if (cnt_reg == half_in - 8'h01)
		begin
			cnt_reg <= 8'h00;
			pin_out <= ~pin_out;
			if (!pin_out)
				rises_out <= rises_out + 1;
			else
				falls_out <= falls_out + 1;
		end
		else
			cnt_reg <= cnt_reg + 8'h01;
	end
endmodule

// >>> test/tb.sv
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
module tb
	import pwm_timer_pkg::*;
;
	typedef struct {
		logic [MODE_W-1:0] mode;
		logic [DATA_W-1:0] top;
		logic [DATA_W-1:0] cmp_a;
		logic [DATA_W-1:0] cmp_b;
		logic [COM_W-1:0]  com_a;
		logic [COM_W-1:0]  com_b;
		logic              ch;
		int                win;
		int                exp;
	} pwm_case_t;

	logic              clk;
	logic              rstn;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr_en;
	logic              rd_en;
	logic              pin;
	logic [DATA_W-1:0] rdata;
	logic              out_a;
	logic              out_b;
	logic              irq;
	logic              src_en;
	logic [7:0]        src_half;
	logic              lvl;
	logic              prev;
	int                rises;
	int                falls;
	int                base;
	int                n;
	int                errors;
	int                n_compared;
	int                prescale [4] = '{8, 64, 256, 1024};
	// high counts hold over whole periods, so the phase of the window does not matter
	pwm_case_t         cases [8] = '{
		'{MODE_PFC_CAPTURE, 16'h0005, 16'h0001, 16'h0002, COM_OFF, COM_NONINV, 1'b0, 40, 16},
		'{MODE_PC_CAPTURE, 16'h0005, 16'h0001, 16'h0002, COM_OFF, COM_INV, 1'b0, 40, 24},
		'{MODE_PFC_CAPTURE, 16'h0005, 16'h0000, 16'h0000, COM_NONINV, COM_NONINV, 1'b0, 40, 0},
		'{MODE_PFC_CAPTURE, 16'h0005, 16'h0001, 16'h0005, COM_OFF, COM_NONINV, 1'b0, 40, 40},
		'{MODE_PFC_CAPTURE, 16'h0005, 16'h0001, 16'h0000, COM_OFF, COM_INV, 1'b0, 40, 40},
		'{MODE_PFC_CAPTURE, 16'h0005, 16'h0001, 16'h0005, COM_OFF, COM_INV, 1'b0, 40, 0},
		'{MODE_PFC_CMPA, 16'h0005, 16'h0007, 16'h0002, COM_OFF, COM_NONINV, 1'b0, 42, 12},
		'{MODE_PC_CMPA, 16'h0005, 16'h0004, 16'h0000, COM_TOGGLE, COM_OFF, 1'b1, 32, 16}
	};

	pwm_timer16 i_pwm_timer16
	(
		.addr_in              (addr),
		.core_clk_in          (clk),
		.rstn_in              (rstn),
		.wr_data_in           (wdata),
		.wr_en_in             (wr_en),
		.rd_en_in             (rd_en),
		.ext_count_pin_in     (pin),
		.rd_data_out          (rdata),
		.compare_output_a_out (out_a),
		.compare_output_b_out (out_b),
		.irq_out              (irq)
	);

	ext_clock_source i_ext_clock_source
	(
		.core_clk_in (clk),
		.en_in       (src_en),
		.half_in     (src_half),
		.pin_out     (pin),
		.rises_out   (rises),
		.falls_out   (falls)
	);

	// ------------------------------------------------------------
	// bus, compare and closing tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic fail(input string msg);
		errors++;
		$display("ERROR %0t %s", $time, msg);
	endtask

	task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_compared++;
		if (got !== exp)
			fail($sformatf("read %h expected %h", got, exp));
	endtask

	task automatic check_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
			fail($sformatf("irq %b expected %b", got, exp));
	endtask

	task automatic check_count(input int got, input int exp);
		n_compared++;
		if (got != exp)
			fail($sformatf("level count %0d expected %0d", got, exp));
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so look mid-cycle
	task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		check_word(rdata, exp);
	endtask

	task automatic reset_dut();
		// reset is applied on a rising edge like every other input
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
	endtask

	task automatic measure(input logic ch, input int win, input int exp);
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		repeat (win)
		begin
			@(negedge clk);
			if ((ch ? out_a : out_b) === 1'b1)
				hi++;
			else if ((ch ? out_a : out_b) === 1'b0)
				lo++;
		end
		check_count(hi, exp);
		check_count(lo, win - exp);
	endtask

	// ------------------------------------------------------------
	// clock, hang guard and main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		#1000000;
		fail("run timed out");
		test_done();
	end

	initial
	begin
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		src_en = 1'b0;
		src_half = 8'h03;
		errors = 0;
		n_compared = 0;
		reset_dut();
		// reset values, then the unmapped hole at 0x1c ignores writes
		for (int i = 0; i < 8; i++)
			rd_check(8'(i * 4), 16'h0000);
		wr(8'h1c, 16'hffff);
		rd_check(8'h1c, 16'h0000);
		// pin clock, rising then falling edges, prescaler bypassed
		for (int p = 0; p < 2; p++)
		begin
			lvl = (p == 0);
			base = lvl ? rises : falls;
			wr(COUNT_OFS, 16'h0000);
			wr(CTRL_OFS, {5'h00, (lvl ? CS_EXT_RISE : CS_EXT_FALL), 8'h00});
			src_en <= 1'b1;
			prev = pin;
			n = 0;
			while (!(pin === lvl && prev !== lvl))
			begin
				prev = pin;
				@(posedge clk);
				#1;
				n++;
				if (n > 50)
				begin
					fail("no pin edge");
					test_done();
				end
			end
			rd_check(COUNT_OFS, 16'h0000);
			rd_check(COUNT_OFS, 16'h0001);
			repeat (100) @(posedge clk);
			src_en <= 1'b0;
			repeat (6) @(posedge clk);
			wr(CTRL_OFS, 16'h0000);
			rd_check(COUNT_OFS, 16'((lvl ? rises : falls) - base));
		end
		// free-running prescaler: any run of 8 divider periods holds exactly 8 ticks
		for (int d = 0; d < 4; d++)
		begin
			wr(COUNT_OFS, 16'h0000);
			wr(CTRL_OFS, {5'h00, CS_DIV8 + 3'(d), 8'h00});
			repeat (8 * prescale[d] - 2) @(posedge clk);
			wr(CTRL_OFS, 16'h0000);
			rd_check(COUNT_OFS, 16'h0008);
		end
		// dual-slope waveforms, one run per table row
		foreach (cases[i])
		begin
			reset_dut();
			wr(CMP_A_OFS, cases[i].cmp_a);
			wr(CMP_B_OFS, cases[i].cmp_b);
			wr(CAPTURE_OFS, cases[i].top);
			wr(CTRL_OFS, {5'h00, CS_DIV1, cases[i].com_b, cases[i].com_a, cases[i].mode});
			repeat (30) @(posedge clk);
			measure(cases[i].ch, cases[i].win, cases[i].exp);
		end
		// flags, mask and the interrupt line
		reset_dut();
		wr(CMP_A_OFS, 16'h0001);
		wr(CMP_B_OFS, 16'h0002);
		wr(CAPTURE_OFS, 16'h0005);
		wr(CTRL_OFS, {5'h00, CS_DIV1, COM_NONINV, COM_OFF, MODE_PFC_CAPTURE});
		repeat (30) @(posedge clk);
		wr(CTRL_OFS, {5'h00, CS_STOP, COM_NONINV, COM_OFF, MODE_PFC_CAPTURE});
		rd_check(STATUS_OFS, 16'h0007);
		check_bit(irq, 1'b0);
		wr(MASK_OFS, 16'h0001);
		@(negedge clk);
		check_bit(irq, 1'b1);
		wr(STATUS_OFS, 16'h0001);
		@(negedge clk);
		check_bit(irq, 1'b0);
		rd_check(STATUS_OFS, 16'h0006);
		wr(MASK_OFS, 16'h0006);
		@(negedge clk);
		check_bit(irq, 1'b1);
		wr(STATUS_OFS, 16'h0006);
		@(negedge clk);
		check_bit(irq, 1'b0);
		rd_check(STATUS_OFS, 16'h0000);
		rd_check(MASK_OFS, 16'h0006);
		test_done();
	end
endmodule
